// ---- rastk_consts.vh ----
// Constants for the return address stack block: register map, fields, resets, vectors
`ifndef RASTK_CONSTS_VH
`define RASTK_CONSTS_VH

`define RASTK_PC_W 21
`define RASTK_PTR_W 5
`define RASTK_DEPTH 5'h1f
`define RASTK_PTR_ZERO 5'h00
`define RASTK_PTR_ONE 5'h01
`define RASTK_PC_STEP 21'h000002

// Register byte addresses
`define RASTK_ADDR_W 8
`define RASTK_OFS_POINTER 8'h00
`define RASTK_OFS_TOP_UPPER 8'h04
`define RASTK_OFS_TOP_HIGH 8'h08
`define RASTK_OFS_TOP_LOW 8'h0c
`define RASTK_OFS_CONFIG 8'h10

// Pointer register fields
`define RASTK_BIT_FULL 7
`define RASTK_BIT_UNDER 6
`define RASTK_PTR_MSB 4

// Top entry slices
`define RASTK_UPPER_MSB 20
`define RASTK_UPPER_LSB 16
`define RASTK_HIGH_MSB 15
`define RASTK_HIGH_LSB 8
`define RASTK_LOW_MSB 7
`define RASTK_LOW_LSB 0

// Configuration register
`define RASTK_BIT_ERR_RST 0
`define RASTK_ERR_RST_RESET 1'b1

// Program memory map
`define RASTK_VEC_RESET 21'h000000
`define RASTK_VEC_HIGH 21'h000008
`define RASTK_VEC_LOW 21'h000018
`define RASTK_PMEM_END 21'h008000
`define RASTK_FETCH_W 16
`define RASTK_FETCH_NOP 16'h0000

// AXI responses
`define RASTK_RESP_OKAY 2'h0
`define RASTK_RESP_SLVERR 2'h2

`endif

// ---- rastk_return_address_stack.v ----
// Return address stack with top-of-stack access, pointer flags and an AXI4-Lite register slave
`timescale 1ns/1ps
`include "rastk_consts.vh"

// Notes on behaviour
// - Fetches above implemented memory, up to 2 Mbyte top, return zero (a no-op).
// - Execution starts at 0000h after reset; interrupt vectors are 0008h and 0018h.
// - Calls, relative calls and interrupt acknowledge push the current program counter.
// - Return, return-with-literal and return-from-interrupt load the program counter from stack.
// - Calls and returns never touch the program counter upper and high latches.
// - Storage is 31 entries of 21 bits addressed by a 5-bit pointer.
// - Every reset clears the pointer; pointer zero has no entry, first push lands in one.
// - A push increments the pointer first, then writes the new entry.
// - A pop reads the current entry first, then decrements the pointer.
// - Upper, high and low top-entry registers read and write the selected entry.
// - Software reads and writes the pointer, range 0 to 31.
// - The 31st push sets the sticky full flag; only software or power-on clears it.
// - With error reset enabled, the 31st push stores pc plus two, flags, resets, pointer zero.
// - With error reset disabled, the pointer stops at 31 and further pushes are dropped.
// - Return on empty loads zero; any pop on empty sets sticky underflow, pointer stays zero.
// - With error reset enabled an underflow also resets the device.
// - Explicit push stores the program counter in a new top entry, no redirect.
// - Explicit pop only decrements the pointer, program counter unchanged.
// - Pointer register: bit 7 full, bit 6 underflow, bit 5 zero, bits 4-0 pointer.
// - Instruction fetch and data access use separate buses and may coincide.
module rastk_return_address_stack (
    // Clock and power-on reset
    input wire i_clk_sys,
    input wire i_resetn,
    // Any other device reset, one-cycle pulse
    input wire i_dev_reset,
    // Core stack requests, one-cycle pulses
    input wire i_call_push,
    input wire i_irq_ack,
    input wire i_irq_high,
    input wire i_push_instr,
    input wire i_return_pop,
    input wire i_pop_instr,
    input wire [20:0] i_pc,
    // Program fetch port
    input wire i_fetch_req,
    input wire [20:0] i_fetch_addr,
    input wire [15:0] i_fetch_mem_data,
    // Core results
    output reg o_pc_load,
    output reg [20:0] o_pc_value,
    output reg o_dev_reset_req,
    output reg o_fetch_valid,
    output reg [15:0] o_fetch_data,
    // AXI4-Lite write address and data
    input wire i_awvalid,
    output reg o_awready,
    input wire [7:0] i_awaddr,
    input wire i_wvalid,
    output reg o_wready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    // AXI4-Lite write response
    output reg o_bvalid,
    input wire i_bready,
    output reg [1:0] o_bresp,
    // AXI4-Lite read
    input wire i_arvalid,
    output reg o_arready,
    input wire [7:0] i_araddr,
    output reg o_rvalid,
    input wire i_rready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp
);

    reg [20:0] stack_mem [1:31];
    reg [4:0] ptr;
    reg stack_full_flag;
    reg stack_underflow_flag;
    reg stack_error_reset_enable;

    reg aw_held;
    reg [7:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire do_push;
    wire do_pop;
    wire [4:0] ptr_inc;
    wire [4:0] ptr_dec;
    wire [20:0] top_entry;
    wire wr_fire;
    wire sw_ptr_wr;
    wire sw_cfg_wr;
    wire sw_upper_wr;
    wire sw_high_wr;
    wire sw_low_wr;
    wire ptr_lane;
    wire [7:0] ptr_wbyte;

    reg [4:0] next_ptr;
    reg next_full_set;
    reg next_under_set;
    reg next_err_reset;
    reg next_pc_load;
    reg [20:0] next_pc_value;
    reg next_mem_wr;
    reg [20:0] next_mem_data;
    reg [31:0] rd_word;
    reg rd_ok;
    reg wr_ok;

    // Interrupt acknowledge pushes just like a call; call and explicit push do not redirect, only interrupt acknowledge does
    assign do_push = i_call_push | i_irq_ack | i_push_instr;
    assign do_pop = i_return_pop | i_pop_instr;
    assign ptr_inc = ptr + `RASTK_PTR_ONE;
    assign ptr_dec = ptr - `RASTK_PTR_ONE;
    // Pointer zero has no storage; it reads as zero
    assign top_entry = (ptr == `RASTK_PTR_ZERO) ? {`RASTK_PC_W{1'b0}} : stack_mem[ptr];

    assign wr_fire = aw_held & w_held & ~o_bvalid;
    assign sw_ptr_wr = wr_fire & (aw_addr == `RASTK_OFS_POINTER);
    assign sw_cfg_wr = wr_fire & (aw_addr == `RASTK_OFS_CONFIG) & w_strb[0];
    assign sw_upper_wr = wr_fire & (aw_addr == `RASTK_OFS_TOP_UPPER) & w_strb[0];
    assign sw_high_wr = wr_fire & (aw_addr == `RASTK_OFS_TOP_HIGH) & w_strb[0];
    assign sw_low_wr = wr_fire & (aw_addr == `RASTK_OFS_TOP_LOW) & w_strb[0];
    assign ptr_lane = sw_ptr_wr & w_strb[0];
    assign ptr_wbyte = w_data[7:0];

    // Stack operation decode; a core operation wins over a software pointer write in the same cycle
    always @* begin
        next_ptr = ptr;
        next_full_set = 1'b0;
        next_under_set = 1'b0;
        next_err_reset = 1'b0;
        next_pc_load = 1'b0;
        next_pc_value = o_pc_value;
        next_mem_wr = 1'b0;
        next_mem_data = i_pc;
        if (do_push) begin
            if (ptr == `RASTK_DEPTH) begin
                // Stack already holds 31 entries: drop the push, keep the top
                next_full_set = 1'b1;
                next_err_reset = stack_error_reset_enable;
            end else begin
                next_ptr = ptr_inc;
                next_mem_wr = 1'b1;
                if (ptr_inc == `RASTK_DEPTH) begin
                    next_full_set = 1'b1;
                    if (stack_error_reset_enable) begin
                        next_mem_data = i_pc + `RASTK_PC_STEP;
                        next_err_reset = 1'b1;
                    end
                end
            end
        end else if (do_pop) begin
            if (ptr == `RASTK_PTR_ZERO) begin
                next_under_set = 1'b1;
                next_err_reset = stack_error_reset_enable;
                if (i_return_pop) begin
                    next_pc_load = 1'b1;
                    next_pc_value = {`RASTK_PC_W{1'b0}};
                end
            end else begin
                // Entry is read before the pointer moves
                next_ptr = ptr_dec;
                if (i_return_pop) begin
                    next_pc_load = 1'b1;
                    next_pc_value = top_entry;
                end
            end
        end else if (ptr_lane) begin
            next_ptr = ptr_wbyte[`RASTK_PTR_MSB:0];
        end
    end

    // Pointer, device reset request and program counter result
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ptr <= `RASTK_PTR_ZERO;
            o_dev_reset_req <= 1'b0;
            o_pc_load <= 1'b0;
            o_pc_value <= `RASTK_VEC_RESET;
        end else if (i_dev_reset | o_dev_reset_req) begin
            // Any reset, including the one this block requests, returns to the reset vector
            ptr <= `RASTK_PTR_ZERO;
            o_dev_reset_req <= 1'b0;
            o_pc_load <= 1'b1;
            o_pc_value <= `RASTK_VEC_RESET;
        end else begin
            ptr <= next_ptr;
            o_dev_reset_req <= next_err_reset;
            if (i_irq_ack) begin
                o_pc_load <= 1'b1;
                o_pc_value <= i_irq_high ? `RASTK_VEC_HIGH : `RASTK_VEC_LOW;
            end else begin
                // Only the counter is steered; the upper and high latches live elsewhere, untouched
                o_pc_load <= next_pc_load;
                o_pc_value <= next_pc_value;
            end
        end
    end

    // Storage has no reset; entries are only meaningful at or below the pointer
    always @(posedge i_clk_sys) begin
        if (next_mem_wr & ~i_dev_reset & ~o_dev_reset_req) begin
            stack_mem[ptr_inc] <= next_mem_data;
        end else if (~do_push & ~do_pop & (ptr != `RASTK_PTR_ZERO)) begin
            if (sw_upper_wr) begin
                stack_mem[ptr] <= {w_data[4:0], top_entry[`RASTK_HIGH_MSB:0]};
            end else if (sw_high_wr) begin
                stack_mem[ptr] <= {top_entry[`RASTK_UPPER_MSB:`RASTK_UPPER_LSB], w_data[7:0],
                    top_entry[`RASTK_LOW_MSB:0]};
            end else if (sw_low_wr) begin
                stack_mem[ptr] <= {top_entry[`RASTK_UPPER_MSB:`RASTK_HIGH_LSB], w_data[7:0]};
            end
        end
    end

    // Sticky flags: only power-on reset or a software zero clears them, and a set wins
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            stack_full_flag <= 1'b0;
            stack_underflow_flag <= 1'b0;
        end else begin
            if (next_full_set & ~i_dev_reset & ~o_dev_reset_req) begin
                stack_full_flag <= 1'b1;
            end else if (ptr_lane & ~ptr_wbyte[`RASTK_BIT_FULL]) begin
                stack_full_flag <= 1'b0;
            end
            if (next_under_set & ~i_dev_reset & ~o_dev_reset_req) begin
                stack_underflow_flag <= 1'b1;
            end else if (ptr_lane & ~ptr_wbyte[`RASTK_BIT_UNDER]) begin
                stack_underflow_flag <= 1'b0;
            end
        end
    end

    // Error reset enable is a configuration bit; it survives device resets
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            stack_error_reset_enable <= `RASTK_ERR_RST_RESET;
        end else if (sw_cfg_wr) begin
            stack_error_reset_enable <= w_data[`RASTK_BIT_ERR_RST];
        end
    end

    // Fetch port runs beside the register bus, so both may act in one cycle
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fetch_valid <= 1'b0;
            o_fetch_data <= `RASTK_FETCH_NOP;
        end else begin
            o_fetch_valid <= i_fetch_req;
            if (i_fetch_addr >= `RASTK_PMEM_END) begin
                o_fetch_data <= `RASTK_FETCH_NOP;
            end else begin
                o_fetch_data <= i_fetch_mem_data;
            end
        end
    end

    // Write channel: address and data are taken independently, response after both
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= `RASTK_RESP_OKAY;
        end else begin
            o_awready <= ~aw_held & ~o_awready & i_awvalid;
            o_wready <= ~w_held & ~o_wready & i_wvalid;
            if (i_awvalid & o_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid & o_wready) begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (wr_fire) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? `RASTK_RESP_OKAY : `RASTK_RESP_SLVERR;
            end else if (o_bvalid & i_bready) begin
                o_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    always @* begin
        if (aw_addr == `RASTK_OFS_POINTER) begin
            wr_ok = 1'b1;
        end else if (aw_addr == `RASTK_OFS_TOP_UPPER) begin
            wr_ok = 1'b1;
        end else if (aw_addr == `RASTK_OFS_TOP_HIGH) begin
            wr_ok = 1'b1;
        end else if (aw_addr == `RASTK_OFS_TOP_LOW) begin
            wr_ok = 1'b1;
        end else if (aw_addr == `RASTK_OFS_CONFIG) begin
            wr_ok = 1'b1;
        end else begin
            wr_ok = 1'b0;
        end
    end

    // Read decode; bit 5 of the pointer register and all upper bits read zero
    always @* begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        if (i_araddr == `RASTK_OFS_POINTER) begin
            rd_word[`RASTK_BIT_FULL] = stack_full_flag;
            rd_word[`RASTK_BIT_UNDER] = stack_underflow_flag;
            rd_word[`RASTK_PTR_MSB:0] = ptr;
        end else if (i_araddr == `RASTK_OFS_TOP_UPPER) begin
            rd_word[4:0] = top_entry[`RASTK_UPPER_MSB:`RASTK_UPPER_LSB];
        end else if (i_araddr == `RASTK_OFS_TOP_HIGH) begin
            rd_word[7:0] = top_entry[`RASTK_HIGH_MSB:`RASTK_HIGH_LSB];
        end else if (i_araddr == `RASTK_OFS_TOP_LOW) begin
            rd_word[7:0] = top_entry[`RASTK_LOW_MSB:`RASTK_LOW_LSB];
        end else if (i_araddr == `RASTK_OFS_CONFIG) begin
            rd_word[`RASTK_BIT_ERR_RST] = stack_error_reset_enable;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read channel: address taken in one cycle, data the next
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= `RASTK_RESP_OKAY;
        end else begin
            o_arready <= ~o_arready & ~o_rvalid & i_arvalid;
            if (i_arvalid & o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata <= rd_word;
                o_rresp <= rd_ok ? `RASTK_RESP_OKAY : `RASTK_RESP_SLVERR;
            end else if (o_rvalid & i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ---- rastk_stack_sva.sv ----
// Assertion checker for the return address stack ports
`timescale 1ns/1ps
`include "rastk_consts.vh"
module rastk_stack_sva (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire i_dev_reset,
    input wire i_call_push,
    input wire i_irq_ack,
    input wire i_irq_high,
    input wire i_push_instr,
    input wire i_return_pop,
    input wire i_pop_instr,
    input wire i_fetch_req,
    input wire [20:0] i_fetch_addr,
    input wire [15:0] i_fetch_mem_data,
    input wire o_pc_load,
    input wire [20:0] o_pc_value,
    input wire o_dev_reset_req,
    input wire o_fetch_valid,
    input wire [15:0] o_fetch_data
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // A pending reset overrides any stack request in the same cycle
    wire calm = !i_dev_reset && !o_dev_reset_req;
    wire pushing = i_call_push || i_irq_ack || i_push_instr;
    wire quiet_op = (i_call_push || i_push_instr || i_pop_instr) && !i_irq_ack && !i_return_pop;
    AST_RET_LOAD: assert property (calm && i_return_pop && !pushing |=> o_pc_load)
        else $error("return did not load the program counter");
    AST_NO_REDIRECT: assert property (calm && quiet_op |=> !o_pc_load)
        else $error("push or pop changed the program counter");
    AST_VEC_HIGH: assert property (calm && i_irq_ack && i_irq_high |=>
        o_pc_load && o_pc_value == `RASTK_VEC_HIGH)
        else $error("high interrupt vector wrong");
    AST_VEC_LOW: assert property (calm && i_irq_ack && !i_irq_high |=>
        o_pc_load && o_pc_value == `RASTK_VEC_LOW)
        else $error("low interrupt vector wrong");
    AST_DEV_RST: assert property (i_dev_reset |=> o_pc_load && o_pc_value == `RASTK_VEC_RESET)
        else $error("device reset did not restart at the reset vector");
    AST_ERR_RST: assert property (o_dev_reset_req |=> !o_dev_reset_req && o_pc_load && o_pc_value == 21'h0)
        else $error("stack error reset not a single pulse followed by restart");
    AST_FETCH_ZERO: assert property (i_fetch_req && i_fetch_addr >= `RASTK_PMEM_END |=>
        o_fetch_valid && o_fetch_data == `RASTK_FETCH_NOP)
        else $error("fetch beyond memory not zero");
    AST_FETCH_MEM: assert property (i_fetch_req && i_fetch_addr < `RASTK_PMEM_END |=>
        o_fetch_valid && o_fetch_data == $past(i_fetch_mem_data))
        else $error("fetch of implemented memory wrong");
endmodule
bind rastk_return_address_stack rastk_stack_sva i_rastk_stack_sva (.*);

// ---- rastk_core_model.sv ----
// Behavioural core sequencer that issues one-cycle stack requests
`timescale 1ns/1ps
module rastk_core_model (
    input wire i_clk_sys,
    input wire i_sw_edit,
    output reg o_call_push,
    output reg o_irq_ack,
    output reg o_irq_high,
    output reg o_push_instr,
    output reg o_return_pop,
    output reg o_pop_instr,
    output reg o_dev_reset,
    output reg [20:0] o_pc
);
    initial {o_call_push, o_irq_ack, o_irq_high, o_push_instr, o_return_pop, o_pop_instr, o_dev_reset} = 7'h00;
    initial o_pc = 21'h0;
    // Kinds: 1 call, 2/3 interrupt high/low, 4 push, 5 return, 6 pop, 7 reset
    task op(input [2:0] k, input [20:0] v);
        begin
            @(posedge i_clk_sys);
            o_call_push <= k == 3'h1;
            o_irq_ack <= (k == 3'h2 || k == 3'h3) && !i_sw_edit;
            o_irq_high <= k == 3'h2;
            o_push_instr <= k == 3'h4;
            o_return_pop <= k == 3'h5;
            o_pop_instr <= k == 3'h6;
            o_dev_reset <= k == 3'h7;
            o_pc <= v;
            @(posedge i_clk_sys);
            {o_call_push, o_irq_ack, o_irq_high, o_push_instr, o_return_pop, o_pop_instr, o_dev_reset} <= 7'h00;
            // Counter only qualified by a request, so show a changed value afterwards
            o_pc <= ~v;
        end
    endtask
endmodule

// ---- tb_rastk_return_address_stack.sv ----
// Self-checking testbench for the return address stack
`timescale 1ns/1ps
`include "rastk_consts.vh"
module tb_rastk_return_address_stack;
reg clk = 1'b0, resetn = 1'b1, sw_edit = 1'b0, fetch_req = 1'b0;
reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
reg [20:0] fetch_addr = 21'h0, p;
reg [15:0] mem_data = 16'h0;
reg [7:0] awaddr = 8'h0, araddr = 8'h0;
reg [31:0] wdata = 32'h0, d;
reg [3:0] wstrb = 4'h0;
reg [1:0] r;
reg [20:0] stk [0:31];
wire call_push, irq_ack, irq_high, push_instr, return_pop, pop_instr, dev_reset;
wire pc_load, dev_req, fetch_valid, awready, wready, bvalid, arready, rvalid;
wire [20:0] pc, pc_value;
wire [15:0] fetch_data;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
integer err_total = 0, total_checks = 0, i;
always #50 clk = ~clk;
rastk_core_model i_rastk_core_model (.i_clk_sys(clk), .i_sw_edit(sw_edit), .o_call_push(call_push),
    .o_irq_ack(irq_ack), .o_irq_high(irq_high), .o_push_instr(push_instr), .o_return_pop(return_pop),
    .o_pop_instr(pop_instr), .o_dev_reset(dev_reset), .o_pc(pc));
rastk_return_address_stack i_rastk_return_address_stack (.i_clk_sys(clk), .i_resetn(resetn),
    .i_dev_reset(dev_reset), .i_call_push(call_push), .i_irq_ack(irq_ack), .i_irq_high(irq_high),
    .i_push_instr(push_instr), .i_return_pop(return_pop), .i_pop_instr(pop_instr), .i_pc(pc),
    .i_fetch_req(fetch_req), .i_fetch_addr(fetch_addr), .i_fetch_mem_data(mem_data), .o_pc_load(pc_load),
    .o_pc_value(pc_value), .o_dev_reset_req(dev_req), .o_fetch_valid(fetch_valid), .o_fetch_data(fetch_data),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp));
function [31:0] ptr_reg(input full, input under, input [4:0] ptr);
    ptr_reg = {24'h0, full, under, 1'b0, ptr};
endfunction
function [20:0] rpc();
    rpc = $urandom & 32'h1ffffe;
endfunction
task check(input [31:0] seen, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
endtask
task wr(input [7:0] a, input [31:0] v);
    reg aw_pend;
    reg w_pend;
    begin
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        // Each channel drops only at the edge where its own ready is seen
        while (aw_pend || w_pend) begin
            @(posedge clk);
            if (aw_pend && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_pend = 1'b0;
            end
            if (w_pend && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_pend = 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        bready <= 1'b0;
        r = bresp;
    end
endtask
task rd(input [7:0] a);
    begin
        @(posedge clk);
        {arvalid, rready} <= 2'h3;
        araddr <= a;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    end
endtask
task go(input [2:0] k, input [20:0] v);
    i_rastk_core_model.op(k, v);
endtask
task pcload(input [20:0] v);
    begin
        #1;
        check(pc_load, 1'b1);
        check(pc_value, v);
    end
endtask
task chk_top(input [20:0] v);
    begin
        rd(`RASTK_OFS_TOP_UPPER);
        check(d, v[20:16]);
        rd(`RASTK_OFS_TOP_HIGH);
        check(d, v[15:8]);
        rd(`RASTK_OFS_TOP_LOW);
        check(d, v[7:0]);
    end
endtask
task chk_ptr(input [31:0] v);
    begin
        rd(`RASTK_OFS_POINTER);
        check(d, v);
    end
endtask
task wrap_up;
    begin
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
endtask
initial begin
    d = $urandom(37800);
    // Drop at time zero so the asynchronous reset sees a real falling edge
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    chk_ptr(ptr_reg(1'b0, 1'b0, 5'h00));
    rd(`RASTK_OFS_CONFIG);
    check(d, 32'h1);
    rd(8'h14);
    check(r, `RASTK_RESP_SLVERR);
    wr(8'h14, 32'h1);
    check(r, `RASTK_RESP_SLVERR);
    for (i = 1; i <= 6; i = i + 1) begin
        stk[i] = rpc();
        go(3'h1, stk[i]);
    end
    chk_ptr(ptr_reg(1'b0, 1'b0, 5'h06));
    chk_top(stk[6]);
    sw_edit <= 1'b1;
    wr(`RASTK_OFS_TOP_LOW, 32'h5a);
    check(r, `RASTK_RESP_OKAY);
    sw_edit <= 1'b0;
    stk[6][7:0] = 8'h5a;
    for (i = 6; i >= 1; i = i - 1) begin
        go(3'h5, 21'h0);
        pcload(stk[i]);
    end
    wr(`RASTK_OFS_CONFIG, 32'h0);
    go(3'h5, 21'h0);
    pcload(21'h0);
    check(dev_req, 1'b0);
    for (i = 1; i <= 31; i = i + 1) begin
        stk[i] = rpc();
        go(3'h1, stk[i]);
    end
    go(3'h1, rpc());
    chk_ptr(ptr_reg(1'b1, 1'b1, 5'h1f));
    chk_top(stk[31]);
    go(3'h6, 21'h0);
    #1 check(pc_load, 1'b0);
    chk_top(stk[30]);
    p = rpc();
    go(3'h4, p);
    chk_top(p);
    go(3'h7, 21'h0);
    pcload(`RASTK_VEC_RESET);
    chk_ptr(ptr_reg(1'b1, 1'b1, 5'h00));
    wr(`RASTK_OFS_POINTER, 32'h3);
    chk_ptr(ptr_reg(1'b0, 1'b0, 5'h03));
    chk_top(stk[3]);
    go(3'h2, p);
    pcload(`RASTK_VEC_HIGH);
    go(3'h3, p + 21'h4);
    pcload(`RASTK_VEC_LOW);
    chk_top(p + 21'h4);
    wr(`RASTK_OFS_CONFIG, 32'h1);
    wr(`RASTK_OFS_POINTER, 32'h1e);
    go(3'h1, p);
    #1 check(dev_req, 1'b1);
    repeat (2) @(posedge clk);
    chk_ptr(ptr_reg(1'b1, 1'b0, 5'h00));
    wr(`RASTK_OFS_POINTER, 32'h9f);
    chk_top(p + `RASTK_PC_STEP);
    wr(`RASTK_OFS_POINTER, 32'h0);
    go(3'h6, 21'h0);
    #1 check(dev_req, 1'b1);
    repeat (2) @(posedge clk);
    chk_ptr(ptr_reg(1'b0, 1'b1, 5'h00));
    for (i = 0; i < 8; i = i + 1) begin
        d = $urandom;
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_addr <= (i == 0) ? `RASTK_PMEM_END : (i[0] ? rpc() | `RASTK_PMEM_END : rpc() & 21'h007ffe);
        mem_data <= d[15:0];
        @(posedge clk);
        fetch_req <= 1'b0;
        #1 check(fetch_valid, 1'b1);
        check(fetch_data, (fetch_addr >= `RASTK_PMEM_END) ? `RASTK_FETCH_NOP : mem_data);
    end
    wrap_up;
end
initial begin
    #(100 * 30000);
    err_total = err_total + 1;
    wrap_up;
end
endmodule
